// *** src/alarm_mon_pkg.sv ***
package alarm_mon_pkg;

    // register addresses on the host port
    localparam logic [7:0]  ADDR_ALARM_STATUS  = 8'h06;
    localparam logic [7:0]  ADDR_ALARM_MASK    = 8'h07;
    localparam logic [7:0]  ADDR_RX_INFO_ONE   = 8'h08;

    // values after reset
    localparam logic [7:0]  RST_STATUS         = 8'h00;
    localparam logic [7:0]  RST_MASK           = 8'h00;
    localparam logic [7:0]  RST_RDATA          = 8'h00;

    // alarm_status bit positions
    localparam int          BIT_UP_CODE        = 7;
    localparam int          BIT_DOWN_CODE      = 6;
    localparam int          BIT_TX_CLK_LOST    = 5;
    localparam int          BIT_UNFRAMED_ONES  = 4;
    localparam int          BIT_CARRIER_LOST   = 3;
    localparam int          BIT_CURRENT_LIMIT  = 2;
    localparam int          BIT_OPEN_CIRCUIT   = 1;
    localparam int          BIT_PSEUDORANDOM   = 0;
    // bits that interrupt on both edges
    localparam logic [7:0]  CHANGE_IRQ_BITS    = 8'h38;
    // latched bits of alarm_status, the rest are real time
    localparam logic [7:0]  LATCHED_BITS       = 8'hD8;

    // receive_info_one bit positions
    localparam int          BIT_ZERO_STRING    = 7;
    localparam int          BIT_SIXTEEN_ZERO   = 6;
    localparam int          BIT_CODEWORD       = 5;
    localparam int          BIT_LOSS_CLEARED   = 4;
    localparam int          BIT_ONES_CLEARED   = 3;
    localparam int          BIT_JITTER_TRIP    = 2;

    // zero-run thresholds in bits
    localparam logic [11:0] ZSTR_E1            = 12'h004;
    localparam logic [11:0] ZSTR_T1            = 12'h008;
    localparam logic [11:0] ZSTR_SIXTEEN       = 12'h010;
    localparam logic [11:0] LOSS_E1            = 12'h0FF;
    localparam logic [11:0] LOSS_E1_ALT        = 12'h800;
    localparam logic [11:0] LOSS_T1            = 12'h0C0;
    localparam logic [11:0] LOSS_T1_ALT        = 12'h608;
    // carrier recovery windows in bits, and ones needed
    localparam logic [7:0]  RECOV_WIN_E1       = 8'hFF;
    localparam logic [7:0]  RECOV_WIN_T1       = 8'h70;
    localparam logic [5:0]  RECOV_ONES_E1      = 6'h20;
    localparam logic [5:0]  RECOV_ONES_T1      = 6'h0E;
    // unframed all-ones windows and zero limits
    localparam logic [8:0]  UA_E1_LAST_BIT     = 9'h1FF;
    localparam logic [3:0]  UA_E1_SET_BELOW    = 4'h2;
    localparam logic [3:0]  UA_E1_CLR_ABOVE    = 4'h2;
    localparam logic [3:0]  UA_T1_SET_MAX      = 4'h5;
    localparam logic [3:0]  UA_T1_CLR_MIN      = 4'h6;

    // timing
    localparam int          CLK_PERIOD_NS      = 10;
    localparam int          TX_CLK_LOSS_NS     = 5000;
    localparam int          TX_CLK_LOSS_CYC    = TX_CLK_LOSS_NS / CLK_PERIOD_NS;
    localparam int          UA_T1_WIN_NS       = 3000000;
    localparam int          UA_T1_WIN_CYC      = UA_T1_WIN_NS / CLK_PERIOD_NS;

    // jitter attenuator fill limits
    localparam logic [6:0]  JA_TOP_TRIP        = 7'h7B;
    localparam logic [6:0]  JA_BOTTOM_TRIP     = 7'h04;

    typedef struct packed {
        logic up_code_seen;
        logic down_code_seen;
        logic tx_current_limit_hit;
        logic tx_open_circuit;
        logic pseudorandom_seen;
        logic line_codeword_seen;
    } alarm_in_t;

endpackage : alarm_mon_pkg

// *** src/line_alarm_status_monitor.sv ***
// Function
// - latch up-code bit while up pattern received
// - latch down-code bit while down pattern received
// - tx clock idle 5us sets bit and pin
// - latch unframed all-ones bit on detection
// - E1 all-ones: zeros per 512 bits
// - T1 all-ones: zeros per 3ms window
// - latch carrier-loss bit while loss exists
// - E1 loss after 255 or 2048 zeros
// - E1 recovery: 32 ones in 255 bits
// - T1 loss after 192 or 1544 zeros
// - T1 recovery: 14 ones in 112 bits
// - current-limit bit follows limiter, real time
// - open-circuit bit follows detector, real time
// - pseudorandom bit follows pattern detector
// - mask bit one enables status interrupt
// - zero-string bit: 4 E1, 8 T1
// - sixteen-zero bit on 16-zero run
// - codeword bit on line codeword seen
// - latch carrier-loss-cleared on recovery
// - latch all-ones-cleared when all-ones ends
// - jitter trip within 4 of limit
// - latched bits clear on read unless persisting
// - mask write selects bits to refresh
// - change or set interrupts; read releases
`timescale 1ns/1ps
`default_nettype none

module line_alarm_status_monitor #(
    parameter int T1_UA_WIN_CYC = alarm_mon_pkg::UA_T1_WIN_CYC
) (
    input  wire logic                    ref_clk,              // 100 MHz clock
    input  wire logic                    rstn,                 // async reset, active low
    input  wire logic [7:0]              host_addr,            // register address
    input  wire logic [7:0]              host_wdata,           // write data
    input  wire logic                    host_wr,              // write pulse
    input  wire logic                    host_rd,              // read pulse
    output logic      [7:0]              host_rdata,           // read data, next cycle
    output logic                         int_n,                // interrupt, active low
    input  wire logic                    tx_line_clock,        // transmit line clock pin
    output logic                         tx_clock_lost,        // clock-loss pin
    input  wire logic                    rx_line_clk,          // recovered receive clock pin
    input  wire logic                    rx_line_pos,          // receive positive rail pin
    input  wire logic                    rx_line_neg,          // receive negative rail pin
    input  wire logic                    line_standard_select, // 0 E1, 1 T1
    input  wire logic                    loss_alt_threshold,   // long zero-run threshold
    input  wire alarm_mon_pkg::alarm_in_t alarm_in,            // detector levels
    input  wire logic [6:0]              ja_fill               // jitter buffer fill
);

    // pin synchronisers: tx clock, rx clock, pos, neg
    logic [3:0]  pin_meta_q;
    logic [3:0]  pin_sync_q;
    logic [1:0]  clk_prev_q;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pin_meta_q <= 4'h0;
            pin_sync_q <= 4'h0;
            clk_prev_q <= 2'h0;
        end else begin
            pin_meta_q <= {tx_line_clock, rx_line_clk, rx_line_pos, rx_line_neg};
            pin_sync_q <= pin_meta_q;
            clk_prev_q <= pin_sync_q[3:2];
        end
    end

    wire         tx_edge  = pin_sync_q[3] ^ clk_prev_q[1];
    wire         bit_stb  = pin_sync_q[2] & ~clk_prev_q[0];
    wire         rx_one   = pin_sync_q[1] | pin_sync_q[0];
    wire         is_t1    = line_standard_select;

    // transmit clock loss watchdog
    localparam logic [9:0] LOSS_CYC = 10'(alarm_mon_pkg::TX_CLK_LOSS_CYC);
    logic [9:0]  idle_q;
    logic        lost_q;
    wire  [9:0]  idle_d   = tx_edge ? 10'h000 : (lost_q ? idle_q : idle_q + 10'h001);
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            idle_q <= 10'h000;
            lost_q <= 1'b0;
        end else begin
            idle_q <= idle_d;
            lost_q <= !tx_edge && (idle_d >= LOSS_CYC);
        end
    end

    // zero run length, saturating
    logic [11:0] run_q;
    wire  [11:0] run_d    = rx_one ? 12'h000 : ((&run_q) ? run_q : run_q + 12'h001);
    wire  [11:0] loss_thr = is_t1 ? (loss_alt_threshold ? alarm_mon_pkg::LOSS_T1_ALT
                                                        : alarm_mon_pkg::LOSS_T1)
                                  : (loss_alt_threshold ? alarm_mon_pkg::LOSS_E1_ALT
                                                        : alarm_mon_pkg::LOSS_E1);
    wire  [11:0] zstr_thr = is_t1 ? alarm_mon_pkg::ZSTR_T1 : alarm_mon_pkg::ZSTR_E1;
    wire         zstr_ev  = bit_stb && (run_d >= zstr_thr);
    wire         z16_ev   = bit_stb && (run_d >= alarm_mon_pkg::ZSTR_SIXTEEN);

    // carrier loss with windowed recovery opened by the first one
    logic        loss_q;
    logic        win_on_q;
    logic [7:0]  win_bits_q;
    logic [5:0]  win_ones_q;
    wire  [7:0]  win_len  = is_t1 ? alarm_mon_pkg::RECOV_WIN_T1 : alarm_mon_pkg::RECOV_WIN_E1;
    wire  [5:0]  win_need = is_t1 ? alarm_mon_pkg::RECOV_ONES_T1 : alarm_mon_pkg::RECOV_ONES_E1;
    wire         win_open = win_on_q | rx_one;
    wire  [7:0]  bits_nx  = win_on_q ? win_bits_q + 8'h01 : 8'h01;
    wire  [5:0]  ones_nx  = (win_on_q ? win_ones_q : 6'h00) + {5'h00, rx_one};
    wire         loss_set = bit_stb && !loss_q && (run_d >= loss_thr);
    wire         recover  = bit_stb && loss_q && win_open && (ones_nx >= win_need);
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            run_q      <= 12'h000;
            loss_q     <= 1'b0;
            win_on_q   <= 1'b0;
            win_bits_q <= 8'h00;
            win_ones_q <= 6'h00;
        end else if (bit_stb) begin
            run_q      <= run_d;
            loss_q     <= loss_set | (loss_q & ~recover);
            win_on_q   <= loss_q && !recover && win_open && (bits_nx < win_len);
            win_bits_q <= bits_nx;
            win_ones_q <= ones_nx;
        end
    end

    // unframed all ones: bit window in E1, time window in T1
    logic [8:0]  ua_bits_q;
    logic [18:0] ua_time_q;
    logic [3:0]  ua_zero_q;
    logic        ua_q;
    wire         t1_end   = ua_time_q >= 19'(T1_UA_WIN_CYC - 1);
    wire         e1_end   = bit_stb && (ua_bits_q == alarm_mon_pkg::UA_E1_LAST_BIT);
    wire         ua_end   = is_t1 ? t1_end : e1_end;
    wire  [3:0]  zero_nx  = ((&ua_zero_q) || rx_one || !bit_stb) ? ua_zero_q
                                                                 : ua_zero_q + 4'h1;
    wire         ua_set   = ua_end && (is_t1 ? (zero_nx <= alarm_mon_pkg::UA_T1_SET_MAX)
                                             : (zero_nx <  alarm_mon_pkg::UA_E1_SET_BELOW));
    wire         ua_clr   = ua_end && (is_t1 ? (zero_nx >= alarm_mon_pkg::UA_T1_CLR_MIN)
                                             : (zero_nx >  alarm_mon_pkg::UA_E1_CLR_ABOVE));
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ua_bits_q <= 9'h000;
            ua_time_q <= 19'h00000;
            ua_zero_q <= 4'h0;
            ua_q      <= 1'b0;
        end else begin
            ua_bits_q <= bit_stb ? ua_bits_q + 9'h001 : ua_bits_q;
            ua_time_q <= t1_end ? 19'h00000 : ua_time_q + 19'h00001;
            ua_zero_q <= ua_end ? 4'h0 : zero_nx;
            ua_q      <= ua_set | (ua_q & ~ua_clr);
        end
    end

    // host register port
    wire         at_status = (host_addr == alarm_mon_pkg::ADDR_ALARM_STATUS);
    wire         at_mask   = (host_addr == alarm_mon_pkg::ADDR_ALARM_MASK);
    wire         at_info   = (host_addr == alarm_mon_pkg::ADDR_RX_INFO_ONE);
    wire         wr_status = host_wr && at_status;
    wire         wr_mask   = host_wr && at_mask;
    wire         wr_info   = host_wr && at_info;
    wire         rd_status = host_rd && at_status;
    wire         rd_info   = host_rd && at_info;

    logic [7:0]  st_latch_q;
    logic [7:0]  st_view_q;
    logic [7:0]  st_sel_q;
    logic [7:0]  in_latch_q;
    logic [7:0]  in_view_q;
    logic [7:0]  in_sel_q;
    logic [7:0]  mask_q;
    logic [7:0]  pend_q;
    logic [7:0]  irq_src_q;
    logic        ua_prev_q;
    logic        loss_prev_q;

    // read clears what the last mask write exposed as set
    wire  [7:0]  st_clr  = rd_status ? (st_view_q & st_sel_q) : 8'h00;
    wire  [7:0]  in_clr  = rd_info ? (in_view_q & in_sel_q) : 8'h00;

    wire  [7:0]  st_set;
    assign st_set[alarm_mon_pkg::BIT_UP_CODE]       = alarm_in.up_code_seen;
    assign st_set[alarm_mon_pkg::BIT_DOWN_CODE]     = alarm_in.down_code_seen;
    assign st_set[alarm_mon_pkg::BIT_TX_CLK_LOST]   = 1'b0;
    assign st_set[alarm_mon_pkg::BIT_UNFRAMED_ONES] = ua_q;
    assign st_set[alarm_mon_pkg::BIT_CARRIER_LOST]  = loss_q;
    assign st_set[alarm_mon_pkg::BIT_CURRENT_LIMIT] = 1'b0;
    assign st_set[alarm_mon_pkg::BIT_OPEN_CIRCUIT]  = 1'b0;
    assign st_set[alarm_mon_pkg::BIT_PSEUDORANDOM]  = 1'b0;

    wire  [7:0]  st_live;
    assign st_live[7:6] = st_latch_q[7:6];
    assign st_live[5]   = lost_q;
    assign st_live[4:3] = st_latch_q[4:3];
    assign st_live[2]   = alarm_in.tx_current_limit_hit;
    assign st_live[1]   = alarm_in.tx_open_circuit;
    assign st_live[0]   = alarm_in.pseudorandom_seen;

    wire         ja_trip = (ja_fill >= alarm_mon_pkg::JA_TOP_TRIP)
                        || (ja_fill <= alarm_mon_pkg::JA_BOTTOM_TRIP);
    wire  [7:0]  in_set;
    assign in_set[alarm_mon_pkg::BIT_ZERO_STRING]  = zstr_ev;
    assign in_set[alarm_mon_pkg::BIT_SIXTEEN_ZERO] = z16_ev;
    assign in_set[alarm_mon_pkg::BIT_CODEWORD]     = alarm_in.line_codeword_seen;
    assign in_set[alarm_mon_pkg::BIT_LOSS_CLEARED] = recover;
    assign in_set[alarm_mon_pkg::BIT_ONES_CLEARED] = ua_prev_q & ~ua_q;
    assign in_set[alarm_mon_pkg::BIT_JITTER_TRIP]  = ja_trip;
    assign in_set[1:0] = 2'b00;

    // interrupt sources: level of change-type alarms, set state of the rest
    wire  [7:0]  irq_src = {st_live[7:6], lost_q, ua_q, loss_q, st_live[2:0]};
    wire  [7:0]  irq_ev  = ((irq_src ^ irq_src_q) & alarm_mon_pkg::CHANGE_IRQ_BITS)
                         | (irq_src & ~irq_src_q & ~alarm_mon_pkg::CHANGE_IRQ_BITS);
    wire  [7:0]  pend_d  = irq_ev | (pend_q & ~st_clr);

    wire  [7:0]  rdata_d = at_status ? st_view_q
                         : at_mask   ? mask_q
                         : at_info   ? in_view_q
                         : 8'h00;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_latch_q  <= alarm_mon_pkg::RST_STATUS;
            st_view_q   <= alarm_mon_pkg::RST_STATUS;
            st_sel_q    <= alarm_mon_pkg::RST_STATUS;
            in_latch_q  <= alarm_mon_pkg::RST_STATUS;
            in_view_q   <= alarm_mon_pkg::RST_STATUS;
            in_sel_q    <= alarm_mon_pkg::RST_STATUS;
            mask_q      <= alarm_mon_pkg::RST_MASK;
            pend_q      <= alarm_mon_pkg::RST_STATUS;
            irq_src_q   <= alarm_mon_pkg::RST_STATUS;
            ua_prev_q   <= 1'b0;
            loss_prev_q <= 1'b0;
        end else begin
            // set wins over a clear in the same cycle
            st_latch_q  <= ((st_latch_q & ~st_clr) | st_set) & alarm_mon_pkg::LATCHED_BITS;
            in_latch_q  <= (in_latch_q & ~in_clr) | in_set;
            if (wr_status) begin
                st_view_q <= (st_view_q & ~host_wdata) | (st_live & host_wdata);
                st_sel_q  <= host_wdata;
            end
            if (wr_info) begin
                in_view_q <= (in_view_q & ~host_wdata) | (in_latch_q & host_wdata);
                in_sel_q  <= host_wdata;
            end
            if (wr_mask) begin
                mask_q    <= host_wdata;
            end
            pend_q      <= pend_d;
            irq_src_q   <= irq_src;
            ua_prev_q   <= ua_q;
            loss_prev_q <= loss_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            host_rdata    <= alarm_mon_pkg::RST_RDATA;
            int_n         <= 1'b1;
            tx_clock_lost <= 1'b0;
        end else begin
            host_rdata    <= host_rd ? rdata_d : host_rdata;
            int_n         <= ~|(pend_q & mask_q);
            tx_clock_lost <= lost_q;
        end
    end

    // checks
    sequence s_read_status;
        rd_status;
    endsequence

    sequence s_mask_write;
        wr_status;
    endsequence

    a_int_reflects_mask: assert property (@(posedge ref_clk) disable iff (!rstn)
        ##1 (int_n == ~|($past(pend_q) & $past(mask_q))))
        else $error("interrupt does not follow pending and mask");

    a_clock_loss_pin: assert property (@(posedge ref_clk) disable iff (!rstn)
        lost_q |=> tx_clock_lost)
        else $error("clock-loss pin not raised");

    a_clock_loss_time: assert property (@(posedge ref_clk) disable iff (!rstn)
        (tx_edge ##1 !tx_edge [*8]) |-> !lost_q)
        else $error("clock loss declared too early");

    a_loss_run_e1: assert property (@(posedge ref_clk) disable iff (!rstn)
        (bit_stb && !is_t1 && !loss_alt_threshold && !loss_q && !rx_one
         && run_q == 12'h0FE) |=> loss_q)
        else $error("carrier loss not declared at run end");

    a_loss_run_t1: assert property (@(posedge ref_clk) disable iff (!rstn)
        (bit_stb && is_t1 && !loss_q && !rx_one
         && run_q == (loss_alt_threshold ? 12'h607 : 12'h0BF)) |=> loss_q)
        else $error("T1 carrier loss not declared at run end");

    a_loss_latched: assert property (@(posedge ref_clk) disable iff (!rstn)
        loss_q |=> st_latch_q[alarm_mon_pkg::BIT_CARRIER_LOST])
        else $error("carrier-loss bit not latched");

    a_recover_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
        recover |=> (!loss_q && in_latch_q[alarm_mon_pkg::BIT_LOSS_CLEARED]))
        else $error("recovery not reported");

    a_view_refresh: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_mask_write |=> ((st_view_q & ~$past(host_wdata)) ==
                          ($past(st_view_q) & ~$past(host_wdata))))
        else $error("unselected status bits changed on mask write");

    a_read_release: assert property (@(posedge ref_clk) disable iff (!rstn)
        (s_read_status ##0 (st_view_q[alarm_mon_pkg::BIT_TX_CLK_LOST]
         && st_sel_q[alarm_mon_pkg::BIT_TX_CLK_LOST]
         && !irq_ev[alarm_mon_pkg::BIT_TX_CLK_LOST]))
        |=> !pend_q[alarm_mon_pkg::BIT_TX_CLK_LOST])
        else $error("pending clock-loss interrupt not released by read");

    a_change_irq: assert property (@(posedge ref_clk) disable iff (!rstn)
        (loss_prev_q && !loss_q) |=> pend_q[alarm_mon_pkg::BIT_CARRIER_LOST])
        else $error("carrier-loss end did not interrupt");

    a_persist_relatch: assert property (@(posedge ref_clk) disable iff (!rstn)
        (s_read_status ##0 ua_q) |=> st_latch_q[alarm_mon_pkg::BIT_UNFRAMED_ONES])
        else $error("persisting all-ones bit cleared by read");

    a_sixteen_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        z16_ev |=> in_latch_q[alarm_mon_pkg::BIT_SIXTEEN_ZERO])
        else $error("sixteen-zero bit not latched");

    a_zero_string: assert property (@(posedge ref_clk) disable iff (!rstn)
        zstr_ev |=> in_latch_q[alarm_mon_pkg::BIT_ZERO_STRING])
        else $error("zero-string bit not latched");

    a_info_low_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        in_latch_q[1:0] == 2'b00)
        else $error("unassigned info bits set");

endmodule : line_alarm_status_monitor

`default_nettype wire

// *** verif/line_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none

module line_far_end (
    input  wire logic ref_clk,       // bench clock
    input  wire logic tx_run,        // transmit clock runs while high
    output logic      tx_line_clock, // transmit line clock
    output logic      rx_line_clk,   // recovered receive clock
    output logic      rx_line_pos,   // receive positive rail
    output logic      rx_line_neg    // receive negative rail
);
    logic mark_q; // polarity of next mark

    initial begin
        tx_line_clock = 1'b0;
        rx_line_clk   = 1'b0;
        rx_line_pos   = 1'b0;
        rx_line_neg   = 1'b0;
        mark_q        = 1'b0;
    end

    // stands still while stopped
    always begin
        #40;
        if (tx_run) begin
            tx_line_clock = ~tx_line_clock;
        end
    end

    // one bit per four cycles, rails back to zero after each bit
    task automatic send_bits(input int n, input logic b);
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk);
            rx_line_pos = b & ~mark_q;
            rx_line_neg = b & mark_q;
            mark_q      = mark_q ^ b;
            @(negedge ref_clk);
            rx_line_clk = 1'b1;
            repeat (2) @(negedge ref_clk);
            rx_line_clk = 1'b0;
            rx_line_pos = 1'b0;
            rx_line_neg = 1'b0;
        end
    endtask : send_bits
endmodule : line_far_end

`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam logic [7:0] STA = alarm_mon_pkg::ADDR_ALARM_STATUS;
    localparam logic [7:0] MSK = alarm_mon_pkg::ADDR_ALARM_MASK;
    localparam logic [7:0] INF = alarm_mon_pkg::ADDR_RX_INFO_ONE;
    logic                     ref_clk, rstn, host_wr, host_rd, int_n, tx_run;
    logic [7:0]               host_addr, host_wdata, host_rdata, v;
    logic                     tx_line_clock, tx_clock_lost, rx_line_clk;
    logic                     rx_line_pos, rx_line_neg, line_standard_select;
    logic                     loss_alt_threshold;
    alarm_mon_pkg::alarm_in_t alarm_in;
    logic [6:0]               ja_fill;
    int                       err_total, compares;
    int                       sbit[5] = '{7, 6, 2, 1, 0};
    logic [6:0]               fills[5] = '{7'h7A, 7'h7B, 7'h05, 7'h04, 7'h40};
    logic [7:0]               exps[5] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h20};

    line_alarm_status_monitor #(.T1_UA_WIN_CYC(2000)) uut (
        .ref_clk(ref_clk), .rstn(rstn), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata), .int_n(int_n),
        .tx_line_clock(tx_line_clock), .tx_clock_lost(tx_clock_lost), .rx_line_clk(rx_line_clk),
        .rx_line_pos(rx_line_pos), .rx_line_neg(rx_line_neg), .alarm_in(alarm_in),
        .line_standard_select(line_standard_select), .loss_alt_threshold(loss_alt_threshold),
        .ja_fill(ja_fill));
    line_far_end far (.ref_clk(ref_clk), .tx_run(tx_run), .tx_line_clock(tx_line_clock),
        .rx_line_clk(rx_line_clk), .rx_line_pos(rx_line_pos), .rx_line_neg(rx_line_neg));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : wait_cyc

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        host_addr  = a;
        host_wdata = d;
        host_wr    = 1'b1;
        @(negedge ref_clk);
        host_wr    = 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        host_addr = a;
        host_rd   = 1'b1;
        @(negedge ref_clk);
        host_rd   = 1'b0;
        @(negedge ref_clk);
        d = host_rdata;
    endtask : reg_rd

    // mask write, read, write back of the bits read
    task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                        input string what);
        logic [7:0] d;
        reg_wr(a, m);
        reg_rd(a, d);
        reg_wr(a, d & m);
        check(d & m, e, what);
    endtask : poll

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    initial begin
        #400000;
        err_total++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        {rstn, host_wr, host_rd, host_addr, host_wdata} = '0;
        {line_standard_select, loss_alt_threshold, alarm_in} = '0;
        {err_total, compares} = '0;
        tx_run  = 1'b1;
        ja_fill = 7'h40;
        wait_cyc(10);
        rstn = 1'b1;
        wait_cyc(2);
        poll(STA, 8'hFF, alarm_mon_pkg::RST_STATUS, "status reset");
        poll(INF, 8'hFC, 8'h00, "info reset");
        reg_rd(MSK, v);
        check(v, alarm_mon_pkg::RST_MASK, "mask reset");
        reg_wr(MSK, 8'hA5);
        reg_rd(MSK, v);
        check(v, 8'hA5, "mask readback");
        reg_rd(8'h0F, v);
        check(v, 8'h00, "unmapped read");
        reg_wr(MSK, 8'h00);
        $display("test registers done");
        foreach (sbit[k]) begin
            alarm_in[5-k] = 1'b1;
            wait_cyc(3);
            poll(STA, 8'h01 << sbit[k], 8'h01 << sbit[k], "status set");
            alarm_in[5-k] = 1'b0;
            wait_cyc(3);
            poll(STA, 8'hFF, (8'h01 << sbit[k]) & 8'hC0, "status after drop");
            poll(STA, 8'hFF, 8'h00, "status drained");
        end
        $display("test detector bits done");
        reg_wr(MSK, 8'h04);
        alarm_in.tx_current_limit_hit = 1'b1;
        wait_cyc(4);
        check({7'h00, int_n}, 8'h00, "irq on set");
        poll(STA, 8'h04, 8'h04, "limit bit");
        wait_cyc(3);
        check({7'h00, int_n}, 8'h01, "irq released");
        alarm_in.tx_open_circuit = 1'b1;
        wait_cyc(4);
        check({7'h00, int_n}, 8'h01, "masked irq");
        reg_wr(MSK, 8'h06);
        wait_cyc(3);
        check({7'h00, int_n}, 8'h00, "unmasked irq");
        poll(STA, 8'h02, 8'h02, "open bit");
        wait_cyc(3);
        check({7'h00, int_n}, 8'h01, "irq released");
        alarm_in = '0;
        reg_wr(MSK, 8'h08);
        $display("test interrupt done");
        far.send_bits(254, 1'b0);
        wait_cyc(10);
        check({7'h00, int_n}, 8'h01, "no loss at 254");
        far.send_bits(1, 1'b0);
        wait_cyc(10);
        check({7'h00, int_n}, 8'h00, "irq on loss");
        poll(STA, 8'h08, 8'h08, "loss set");
        wait_cyc(3);
        check({7'h00, int_n}, 8'h01, "loss irq released");
        poll(INF, 8'hC0, 8'hC0, "zero runs");
        far.send_bits(255, 1'b1);
        wait_cyc(10);
        check({7'h00, int_n}, 8'h00, "irq on recovery");
        poll(STA, 8'h08, 8'h08, "loss latched");
        poll(STA, 8'h08, 8'h00, "loss gone");
        poll(INF, 8'h10, 8'h10, "loss cleared");
        far.send_bits(1100, 1'b1);
        poll(STA, 8'h10, 8'h10, "all ones");
        for (int i = 0; i < 600; i++) begin
            far.send_bits(1, 1'b0);
            far.send_bits(1, 1'b1);
        end
        poll(INF, 8'h08, 8'h08, "all ones ended");
        $display("test receive line done");
        for (int k = 0; k < 4; k++) begin
            line_standard_select = k[1];
            far.send_bits((k[1] ? 7 : 3) + k[0], 1'b0);
            far.send_bits(1, 1'b1);
            poll(INF, 8'h80, k[0] ? 8'h80 : 8'h00, "zero string");
        end
        far.send_bits(191, 1'b0);
        wait_cyc(10);
        check({7'h00, int_n}, 8'h01, "no loss at 191");
        far.send_bits(1, 1'b0);
        wait_cyc(4);
        poll(STA, 8'h08, 8'h08, "t1 loss");
        far.send_bits(13, 1'b1);
        far.send_bits(99, 1'b0);
        poll(INF, 8'h10, 8'h00, "short window");
        far.send_bits(14, 1'b1);
        poll(INF, 8'h10, 8'h10, "t1 recovery");
        poll(STA, 8'h08, 8'h08, "t1 loss latched");
        loss_alt_threshold = 1'b1;
        far.send_bits(1543, 1'b0);
        poll(STA, 8'h08, 8'h00, "no loss at 1543");
        far.send_bits(1, 1'b0);
        wait_cyc(4);
        poll(STA, 8'h08, 8'h08, "long loss");
        foreach (fills[k]) begin
            ja_fill = fills[k];
            alarm_in.line_codeword_seen = (k == 4);
            wait_cyc(3);
            ja_fill = 7'h40;
            alarm_in.line_codeword_seen = 1'b0;
            poll(INF, 8'h24, exps[k], "info event");
        end
        $display("test info bits done");
        reg_wr(MSK, 8'h20);
        tx_run = 1'b0;
        wait_cyc(280);
        check({7'h00, tx_clock_lost}, 8'h00, "clock not yet lost");
        wait_cyc(440);
        check({7'h00, tx_clock_lost}, 8'h01, "clock lost pin");
        check({7'h00, int_n}, 8'h00, "irq on clock loss");
        poll(STA, 8'h20, 8'h20, "clock loss bit");
        tx_run = 1'b1;
        wait_cyc(20);
        check({7'h00, tx_clock_lost}, 8'h00, "clock back");
        check({7'h00, int_n}, 8'h00, "irq on clock return");
        $display("test clock loss done");
        complete_run();
    end
endmodule : tb

`default_nettype wire
